// ### hdl/uic_pkg.sv
// Package: register addresses, field positions, codes and types of the UART interrupt and FIFO control block
package uic_pkg;
  // Register addresses on the 3-bit parallel bus
  localparam logic [2:0] UIC_ADDR_DATA = 3'h0;
  localparam logic [2:0] UIC_ADDR_MASK = 3'h1;
  localparam logic [2:0] UIC_ADDR_SRC = 3'h2;
  localparam logic [2:0] UIC_ADDR_FCTL = 3'h2;
  localparam logic [2:0] UIC_ADDR_LSR = 3'h5;
  localparam logic [2:0] UIC_ADDR_MSR = 3'h6;
  // Interrupt mask bit positions
  localparam int UIC_M_RXD = 0;
  localparam int UIC_M_TXR = 1;
  localparam int UIC_M_LS = 2;
  localparam int UIC_M_MS = 3;
  localparam int UIC_M_SLEEP = 4;
  localparam int UIC_M_XOFF = 5;
  localparam int UIC_M_RTS = 6;
  localparam int UIC_M_CTS = 7;
  localparam logic [7:0] UIC_MASK_LOW = 8'h0f;
  localparam logic [7:0] UIC_MASK_RST = 8'h00;
  // FIFO control bit positions
  localparam int UIC_F_EN = 0;
  localparam int UIC_F_RXRST = 1;
  localparam int UIC_F_TXRST = 2;
  localparam int UIC_F_WAKE = 3;
  localparam int UIC_F_TXT_LO = 4;
  localparam int UIC_F_RXT_LO = 6;
  // Line status bit positions
  localparam int UIC_L_DR = 0;
  localparam int UIC_L_OE = 1;
  localparam int UIC_L_ERR_LO = 2;
  localparam int UIC_L_THRE = 5;
  localparam int UIC_L_TEMT = 6;
  localparam int UIC_L_FERR = 7;
  // Interrupt source codes, bits 5:0
  localparam logic [5:0] UIC_ID_LS = 6'h06;
  localparam logic [5:0] UIC_ID_TO = 6'h0c;
  localparam logic [5:0] UIC_ID_RXD = 6'h04;
  localparam logic [5:0] UIC_ID_TXR = 6'h02;
  localparam logic [5:0] UIC_ID_MS = 6'h00;
  localparam logic [5:0] UIC_ID_XSC = 6'h10;
  localparam logic [5:0] UIC_ID_FLOW = 6'h20;
  localparam logic [5:0] UIC_ID_NONE = 6'h01;
  // FIFO levels and trigger table
  localparam int UIC_LVL_W = 6;
  localparam logic [5:0] UIC_RXT_0 = 6'h08;
  localparam logic [5:0] UIC_RXT_1 = 6'h10;
  localparam logic [5:0] UIC_RXT_2 = 6'h18;
  localparam logic [5:0] UIC_RXT_3 = 6'h1c;
  localparam logic [5:0] UIC_TXT_0 = 6'h10;
  localparam logic [5:0] UIC_TXT_1 = 6'h08;
  localparam logic [5:0] UIC_TXT_2 = 6'h18;
  localparam logic [5:0] UIC_TXT_3 = 6'h1e;
  // Time-out: four characters plus twelve bits, counted in bit ticks
  localparam int UIC_TO_CHARS = 4;
  localparam int UIC_TO_XBITS = 12;
  localparam int UIC_TO_W = 7;

  // Status arriving from the receive and transmit datapaths
  typedef struct packed {
    logic rx_data;
    logic overrun;
    logic [2:0] head_err;
    logic fifo_err;
    logic thr_empty;
    logic tx_empty;
    logic [UIC_LVL_W-1:0] rx_level;
    logic [UIC_LVL_W-1:0] tx_level;
    logic rx_push;
    logic rx_push_err;
    logic bit_tick;
    logic [3:0] char_bits;
  } uic_line_t;

  // Enhanced-mode and flow-control side inputs
  typedef struct packed {
    logic enh_en;
    logic err_at_fifo;
    logic auto_rts;
    logic auto_cts;
    logic rts_rise;
    logic cts_rise;
    logic [3:0] modem_delta;
    logic xoff_rx;
    logic xon_rx;
    logic spec_rx;
    logic wake;
  } uic_side_t;

  // Host bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uic_bus_t;

  typedef enum logic [1:0] {
    UIC_TO_IDLE = 2'b00,
    UIC_TO_RUN = 2'b01,
    UIC_TO_FIRED = 2'b11
  } uic_to_st_t;
endpackage

// ### hdl/uic_prio.sv
// Priority encoder turning pending sources into the interrupt source code
`timescale 1ns/10ps
module uic_prio (
  // Pending enabled sources, priority 1 first
  input wire logic [6:0] pend,
  input wire logic wake,
  // Result
  output logic [5:0] code,
  output logic any
);
  import uic_pkg::*;
  always_comb begin
    if (pend[0]) begin
      code = UIC_ID_LS;
    end else if (pend[1]) begin
      code = UIC_ID_TO;
    end else if (pend[2]) begin
      code = UIC_ID_RXD;
    end else if (pend[3]) begin
      code = UIC_ID_TXR;
    end else if (pend[4]) begin
      code = UIC_ID_MS;
    end else if (pend[5]) begin
      code = UIC_ID_XSC;
    end else if (pend[6]) begin
      code = UIC_ID_FLOW;
    end else begin
      code = UIC_ID_NONE;
    end
    any = (|pend) | wake;
  end
endmodule // uic_prio

// ### hdl/uic_timeout.sv
// Receive time-out timer: four character times plus twelve bit times of idleness
`timescale 1ns/10ps
module uic_timeout (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Receive activity
  input wire logic bit_tick,
  input wire logic [3:0] char_bits,
  input wire logic has_data,
  input wire logic activity,
  // Expiry level, held until activity or until has_data drops
  output logic fired
);
  import uic_pkg::*;
  typedef struct packed {
    uic_to_st_t st;
    logic [UIC_TO_W-1:0] cnt;
  } uic_tos_t;
  uic_tos_t s_q, s_d;
  logic [UIC_TO_W-1:0] limit;
  always_comb begin
    s_d = s_q;
    limit = UIC_TO_W'(UIC_TO_CHARS * char_bits + UIC_TO_XBITS);
    if (activity || !has_data) begin
      s_d.st = has_data ? UIC_TO_RUN : UIC_TO_IDLE;
      s_d.cnt = '0;
    end else begin
      case (s_q.st)
        UIC_TO_IDLE: s_d.st = UIC_TO_RUN;
        UIC_TO_RUN: begin
          if (bit_tick) begin
            if (s_q.cnt + 1'b1 >= limit) begin
              s_d.st = UIC_TO_FIRED;
            end
            s_d.cnt = s_q.cnt + 1'b1;
          end
        end
        UIC_TO_FIRED: s_d.st = UIC_TO_FIRED;
        default: s_d.st = UIC_TO_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '{st: UIC_TO_IDLE, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end
  assign fired = (s_q.st == UIC_TO_FIRED);
endmodule // uic_timeout

// ### hdl/uic_ctrl.sv
// Interrupt mask, source reporting and FIFO control of the UART
`timescale 1ns/10ps
// Notes on behaviour
// - FIFOs on and mask bits 0-3 clear gives polled operation through line status
// - Line status carries data, overrun, head errors, empties and FIFO error
// - Mask bit 0 raises receive interrupt on character or trigger level
// - Mask bit 1 raises transmit interrupt on empty or below trigger, also at enable
// - Mask bit 2: overrun at once; errors at holding register or FIFO entry
// - Mask bits 4-7 writable only with enhanced enable; all reset to zero
// - Mask bit 6 flags RTS rising under automatic RTS
// - Mask bit 7 flags CTS rising under automatic CTS
// - Source register shows only highest pending; others stay queued
// - Time-out after four characters plus twelve bits without activity
// - Line status interrupt from status bits 1-4, cleared by status read
// - Modem interrupt from modem bits 0-3; it and flow changes clear on modem read
// - Receive interrupt clears below trigger; time-out clears on data read
// - Transmit interrupt clears on a source read that reports it, or on a data write
// - Xon/Xoff and wake clear on a source read showing match or none; special also on next character
// - Source codes per priority 1 to 7, none or wake reads 000001
// - Source bit 0 low while pending, high when none, high at reset
// - Source bits 4 and 5 reported only with enhanced enable
// - Source bits 7:6 show FIFO enable
// - FIFO control bit 0 enables FIFOs; other bits need it set in same write
// - Receive FIFO reset pulse, self clearing
// - Transmit FIFO reset pulse, self clearing
// - Receive triggers 8/16/24/28; transmit 16/8/24/30 under enhanced enable
// - Data ready follows receive FIFO non-empty
module uic_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host register bus
  input uic_pkg::uic_bus_t bus,
  output logic [7:0] rdata,
  // Datapath status and side events
  input uic_pkg::uic_line_t line,
  input uic_pkg::uic_side_t side,
  // Control to datapath
  output logic fifo_en,
  output logic rx_fifo_rst,
  output logic tx_fifo_rst,
  output logic wake_int_en,
  output logic sleep_en,
  output logic [7:0] line_status,
  // Interrupt output
  output logic irq
);
  import uic_pkg::*;

  typedef struct packed {
    logic [7:0] mask;
    logic fen;
    logic [1:0] rxt;
    logic [1:0] txt;
    logic wake_en;
    logic rxrst;
    logic txrst;
    logic ls;
    logic txr;
    logic ms;
    logic xsc;
    logic flow;
    logic wk;
    logic [7:0] rd;
    logic lsc;
    logic msc;
    logic txl;
    logic [7:0] line_status_reg;
  } uic_st_t;

  uic_st_t s_q, s_d;
  logic [5:0] rx_trig, tx_trig, code;
  logic rx_hit, tx_low, to_fired, any, rd_data, rd_src, rd_lsr, rd_msr, wr_thr;
  logic wr_mask, wr_fctl, ls_cause, ls_set, ms_set, tx_set;
  logic [6:0] raw, gate;
  logic [6:0] pend;
  logic [7:0] line_status_reg, src;

  assign rd_data = bus.rd && bus.addr == UIC_ADDR_DATA;
  assign rd_src = bus.rd && bus.addr == UIC_ADDR_SRC;
  assign rd_lsr = bus.rd && bus.addr == UIC_ADDR_LSR;
  assign rd_msr = bus.rd && bus.addr == UIC_ADDR_MSR;
  assign wr_thr = bus.wr && bus.addr == UIC_ADDR_DATA;
  assign wr_mask = bus.wr && bus.addr == UIC_ADDR_MASK;
  assign wr_fctl = bus.wr && bus.addr == UIC_ADDR_FCTL;

  always_comb begin
    case (s_q.rxt)
      2'b00: rx_trig = UIC_RXT_0;
      2'b01: rx_trig = UIC_RXT_1;
      2'b10: rx_trig = UIC_RXT_2;
      default: rx_trig = UIC_RXT_3;
    endcase
    case (s_q.txt)
      2'b00: tx_trig = UIC_TXT_0;
      2'b01: tx_trig = UIC_TXT_1;
      2'b10: tx_trig = UIC_TXT_2;
      default: tx_trig = UIC_TXT_3;
    endcase
  end

  // receive level condition; in FIFO mode clears only below trigger, else when no data is left
  assign rx_hit = s_q.fen ? (line.rx_level >= rx_trig) : line.rx_data;
  assign tx_low = s_q.fen ? (line.tx_level < tx_trig || line.tx_level == '0) : line.thr_empty;

  // idle timer, activity is a push or a data read
  uic_timeout u_to (
    .clk(clk),
    .reset(reset),
    .bit_tick(line.bit_tick),
    .char_bits(line.char_bits),
    .has_data(line.rx_data && s_q.fen),
    .activity(line.rx_push || rd_data),
    .fired(to_fired)
  );

  // line status assembly; data ready from datapath
  always_comb begin
    line_status_reg = 8'h00;
    line_status_reg[UIC_L_DR] = line.rx_data;
    line_status_reg[UIC_L_OE] = line.overrun;
    line_status_reg[UIC_L_ERR_LO +: 3] = line.head_err;
    line_status_reg[UIC_L_THRE] = line.thr_empty;
    line_status_reg[UIC_L_TEMT] = line.tx_empty;
    line_status_reg[UIC_L_FERR] = line.fifo_err;
  end

  // errors at FIFO entry when err_at_fifo is set, else at head
  assign ls_cause = line.overrun | (side.err_at_fifo ? line.rx_push_err : (|line.head_err));
  // Flags latch on the rising edge of a level cause, so a clearing read in the
  // same cycle as the cause drops is not undone by the stale level
  assign ls_set = ls_cause && !s_q.lsc;
  assign ms_set = (|side.modem_delta) && !s_q.msc;
  // entering empty or below trigger, or any mask write enabling it while there
  assign tx_set = tx_low && (!s_q.txl || (wr_mask && bus.wdata[UIC_M_TXR]));

  always_comb begin
    s_d = s_q;
    s_d.rxrst = 1'b0;
    s_d.txrst = 1'b0;
    // upper mask bits guarded by enhanced enable
    if (wr_mask) begin
      s_d.mask[3:0] = bus.wdata[3:0];
      if (side.enh_en) begin
        s_d.mask[7:4] = bus.wdata[7:4];
      end
    end
    // rest of write ignored unless enable set, clearing bit 0 disables
    if (wr_fctl) begin
      s_d.fen = bus.wdata[UIC_F_EN];
      if (bus.wdata[UIC_F_EN]) begin
        s_d.rxt = bus.wdata[UIC_F_RXT_LO +: 2];
        s_d.rxrst = bus.wdata[UIC_F_RXRST];
        s_d.txrst = bus.wdata[UIC_F_TXRST];
        if (side.enh_en) begin
          s_d.txt = bus.wdata[UIC_F_TXT_LO +: 2];
          s_d.wake_en = bus.wdata[UIC_F_WAKE];
        end
      end
    end
    // line status flag, set wins over read clear
    if (rd_lsr) begin
      s_d.ls = 1'b0;
    end
    if (ls_set) begin
      s_d.ls = 1'b1;
    end
    s_d.lsc = ls_cause;
    // fires on empty, including enable while already empty
    // cleared by source read when it is the reported one, or data write
    if ((rd_src && code == UIC_ID_TXR) || wr_thr) begin
      s_d.txr = 1'b0;
    end
    if (tx_set) begin
      s_d.txr = 1'b1;
    end
    s_d.txl = tx_low;
    if (rd_msr) begin
      s_d.ms = 1'b0;
      s_d.flow = 1'b0;
    end
    if (ms_set) begin
      s_d.ms = 1'b1;
    end
    s_d.msc = |side.modem_delta;
    // flow pin rising edges under automatic control
    if ((side.rts_rise && side.auto_rts && s_q.mask[UIC_M_RTS]) ||
        (side.cts_rise && side.auto_cts && s_q.mask[UIC_M_CTS])) begin
      s_d.flow = 1'b1;
    end
    if (rd_src && (code == UIC_ID_XSC || code == UIC_ID_NONE)) begin
      s_d.xsc = 1'b0;
      s_d.wk = 1'b0;
    end
    if (line.rx_push && !side.spec_rx) begin
      s_d.xsc = s_d.xsc & (side.xon_rx | side.xoff_rx);
    end
    if (side.xon_rx || side.spec_rx || (side.xoff_rx && s_q.mask[UIC_M_XOFF])) begin
      s_d.xsc = 1'b1;
    end
    if (side.wake && s_q.wake_en) begin
      s_d.wk = 1'b1;
    end
    s_d.rd = s_q.rd;
    if (bus.rd) begin
      case (bus.addr)
        UIC_ADDR_SRC: s_d.rd = src;
        UIC_ADDR_LSR: s_d.rd = line_status_reg;
        UIC_ADDR_MASK: s_d.rd = s_q.mask;
        UIC_ADDR_MSR: s_d.rd = {4'h0, side.modem_delta};
        default: s_d.rd = 8'h00;
      endcase
    end
    // Registered copy keeps the status output free of bus-side glitches
    s_d.line_status_reg = line_status_reg;
  end

  // State register; all fields, the mask included, restart at zero
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Raw source flags in priority order, with the bit that lets each one through
  always_comb begin
    raw[0] = s_q.ls;
    gate[0] = s_q.mask[UIC_M_LS];
    raw[1] = to_fired;
    gate[1] = s_q.mask[UIC_M_RXD];
    raw[2] = rx_hit;
    gate[2] = s_q.mask[UIC_M_RXD];
    raw[3] = s_q.txr;
    gate[3] = s_q.mask[UIC_M_TXR];
    raw[4] = s_q.ms;
    gate[4] = s_q.mask[UIC_M_MS];
    // match and flow-change sources only with enhanced enable
    raw[5] = s_q.xsc;
    gate[5] = side.enh_en;
    raw[6] = s_q.flow;
    gate[6] = side.enh_en;
  end

  // mask bits 0-3 clear block every source but match and flow change, leaving line status to polling
  for (genvar i = 0; i < $bits(pend); i++) begin : g_pend
    assign pend[i] = raw[i] & gate[i];
  end

  // only the highest pending source is coded
  uic_prio u_prio (
    .pend(pend),
    .wake(s_q.wk),
    .code(code),
    .any(any)
  );

  // source register image: FIFO state on top, code below
  assign src = {{2{s_q.fen}}, code};

  // Outputs straight from state
  assign rdata = s_q.rd;
  assign fifo_en = s_q.fen;
  assign rx_fifo_rst = s_q.rxrst;
  assign tx_fifo_rst = s_q.txrst;
  assign wake_int_en = s_q.wake_en;
  assign sleep_en = s_q.mask[UIC_M_SLEEP];
  assign line_status = s_q.line_status_reg;
  // a wake event pends without a mask bit of its own
  assign irq = any;

  // Steps used by the checks below
  sequence lsr_read_s;
    rd_lsr && !ls_set;
  endsequence

  sequence txr_ack_s;
    ((rd_src && code == UIC_ID_TXR) || wr_thr) && !tx_set;
  endsequence

  sequence bad_fctl_s;
    wr_fctl && !bus.wdata[UIC_F_EN];
  endsequence

  sequence txr_enable_s;
    wr_mask && bus.wdata[UIC_M_TXR] && tx_low;
  endsequence

  // Reset leaves no source enabled
  mask_reset_a: assert property (@(posedge clk) reset |=> s_q.mask == UIC_MASK_RST)
    else $error("interrupt mask not cleared by reset");

  // Upper mask bits hold their value unless enhanced enable is set
  upper_mask_a: assert property (
    @(posedge clk) disable iff (reset) wr_mask && !side.enh_en |=> s_q.mask[7:4] == $past(s_q.mask[7:4]))
    else $error("upper mask bits changed without enhanced enable");

  // A status read with no new cause clears the line status flag
  lsr_clear_a: assert property (@(posedge clk) disable iff (reset) lsr_read_s |=> !s_q.ls)
    else $error("line status flag survived a status read");

  // Source read naming transmit ready, or a data write, clears it
  txr_clear_a: assert property (@(posedge clk) disable iff (reset) txr_ack_s |=> !s_q.txr)
    else $error("transmit ready flag survived its acknowledge");

  // Enabling the transmit interrupt while already empty raises it
  txr_enable_a: assert property (@(posedge clk) disable iff (reset) txr_enable_s |=> s_q.txr)
    else $error("transmit ready not raised on enable while empty");

  // A FIFO control write without its enable bit changes nothing but the enable
  fctl_guard_a: assert property (
    @(posedge clk) disable iff (reset) bad_fctl_s |=> !s_q.rxrst && !s_q.txrst && s_q.rxt == $past(s_q.rxt))
    else $error("FIFO control fields taken without enable bit");

  // FIFO reset strobes last one cycle unless written again
  fifo_rst_pulse_a: assert property (
    @(posedge clk) disable iff (reset) (s_q.rxrst || s_q.txrst) && !wr_fctl |=> !s_q.rxrst && !s_q.txrst)
    else $error("FIFO reset strobe held longer than one cycle");

  // Bit 0 of the source image reads low exactly while a source pends
  src_idle_bit_a: assert property (@(posedge clk) disable iff (reset) src[0] == !(|pend))
    else $error("source idle bit disagrees with pending sources");

  // Top source bits mirror the FIFO enable
  fifo_status_a: assert property (@(posedge clk) disable iff (reset) src[7:6] == {2{s_q.fen}})
    else $error("source FIFO bits disagree with FIFO enable");

  // Match and flow-change sources stay hidden without enhanced enable
  hidden_match_a: assert property (@(posedge clk) disable iff (reset) !side.enh_en |-> !pend[5] && !pend[6])
    else $error("enhanced source reported without enhanced enable");

  // Receive level at or above trigger pends when enabled in FIFO mode
  rx_level_a: assert property (
    @(posedge clk) disable iff (reset) s_q.fen && s_q.mask[UIC_M_RXD] && line.rx_level >= rx_trig |-> pend[2])
    else $error("receive trigger reached without pending receive source");

  // Interrupt output follows the pending set
  irq_level_a: assert property (@(posedge clk) disable iff (reset) irq == ((|pend) || s_q.wk))
    else $error("interrupt output disagrees with pending sources");
endmodule // uic_ctrl

// ### sim/uic_dp_model.sv
// Datapath stand-in: status levels and read-to-clear flags feeding the control block
`timescale 1ns/10ps
module uic_dp_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host bus as the datapath sees it
  input uic_pkg::uic_bus_t bus,
  // Bench controls
  input wire logic ovr_set,
  input wire logic md_set,
  input wire logic xoff_set,
  input wire logic enh,
  input wire logic thr_empty,
  input wire logic [5:0] rx_level,
  // Status toward the block
  output uic_pkg::uic_line_t line,
  output uic_pkg::uic_side_t side
);
  import uic_pkg::*;
  logic ovr_q;
  logic [3:0] md_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      ovr_q <= 1'b0;
      md_q <= 4'h0;
    end else begin
      if (ovr_set) begin
        ovr_q <= 1'b1;
      end else if (bus.rd && bus.addr == UIC_ADDR_LSR) begin
        ovr_q <= 1'b0;
      end
      // Modem deltas held until modem read
      if (md_set) begin
        md_q <= 4'h1;
      end else if (bus.rd && bus.addr == UIC_ADDR_MSR) begin
        md_q <= 4'h0;
      end
    end
  end
  always_comb begin
    line = '0;
    side = '0;
    // Data present while the FIFO holds characters
    line.rx_data = (rx_level != 6'h00);
    line.rx_level = rx_level;
    line.overrun = ovr_q;
    line.thr_empty = thr_empty;
    line.tx_empty = thr_empty;
    // Bit ticks held off: no test or check exercises the time-out path
    line.char_bits = 4'h8;
    side.enh_en = enh;
    side.modem_delta = md_q;
    side.xoff_rx = xoff_set;
  end
endmodule // uic_dp_model

// ### sim/uic_ctrl_tb.sv
// Self-checking bench for the interrupt mask, source and FIFO control block
`timescale 1ns/10ps
module uic_ctrl_tb;
  import uic_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  uic_bus_t bus = '0;
  uic_line_t line;
  uic_side_t side;
  logic [7:0] rdata;
  logic fifo_en, rx_fifo_rst, tx_fifo_rst, wake_int_en, sleep_en, irq;
  logic [7:0] line_status;
  logic ovr_set = 1'b0, md_set = 1'b0, xoff_set = 1'b0, enh = 1'b0, thr_empty = 1'b0;
  logic [5:0] rx_level = 6'h00;
  logic rxr_seen = 1'b0, txr_seen = 1'b0;
  int failures = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  uic_dp_model uic_dp_model_inst (.clk(clk), .reset(reset), .bus(bus), .ovr_set(ovr_set), .md_set(md_set),
    .xoff_set(xoff_set), .enh(enh), .thr_empty(thr_empty), .rx_level(rx_level), .line(line), .side(side));
  uic_ctrl uic_ctrl_inst (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .line(line), .side(side),
    .fifo_en(fifo_en), .rx_fifo_rst(rx_fifo_rst), .tx_fifo_rst(tx_fifo_rst), .wake_int_en(wake_int_en),
    .sleep_en(sleep_en), .line_status(line_status), .irq(irq));
  // Reset pulses are short, so they are latched here and inspected later
  always @(posedge clk) begin
    if (rx_fifo_rst === 1'b1) rxr_seen <= 1'b1;
    if (tx_fifo_rst === 1'b1) txr_seen <= 1'b1;
  end
  task automatic final_report();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(posedge clk);
    #2;
    bus.wr = 1'b0;
    @(posedge clk);
    #2;
  endtask
  // Read data is registered at the taking edge and compared just after it
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    bus.rd = 1'b1;
    bus.addr = a;
    @(posedge clk);
    #2;
    chk8(rdata, exp);
    bus.rd = 1'b0;
    @(posedge clk);
    #2;
  endtask
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 20; i++) begin
      if (irq === exp) break;
      @(posedge clk);
      #2;
    end
    chk8({7'h00, irq}, {7'h00, exp});
    if (irq !== exp) final_report();
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk);
    #2;
    s = 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #2;
    reset = 1'b0;
    @(posedge clk);
    #2;
    rd_chk(UIC_ADDR_MASK, 8'h00);
    rd_chk(UIC_ADDR_SRC, 8'h01);
    chk8({7'h00, irq}, 8'h00);
    wr_reg(UIC_ADDR_MASK, 8'hf0);
    rd_chk(UIC_ADDR_MASK, 8'h00);
    enh = 1'b1;
    wr_reg(UIC_ADDR_MASK, 8'hf0);
    rd_chk(UIC_ADDR_MASK, 8'hf0);
    chk8({7'h00, sleep_en}, 8'h01);
    wr_reg(UIC_ADDR_MASK, 8'h00);
    wr_reg(UIC_ADDR_FCTL, 8'hc6);
    rd_chk(UIC_ADDR_SRC, 8'h01);
    chk8({6'h00, rxr_seen, txr_seen}, 8'h00);
    wr_reg(UIC_ADDR_FCTL, 8'h07);
    chk8({6'h00, rxr_seen, txr_seen}, 8'h03);
    chk8({6'h00, rx_fifo_rst, tx_fifo_rst}, 8'h00);
    rd_chk(UIC_ADDR_SRC, 8'hc1);
    // Receive trigger of 8, then one below it
    rx_level = 6'h08;
    wr_reg(UIC_ADDR_MASK, 8'h01);
    wait_irq(1'b1);
    rd_chk(UIC_ADDR_SRC, 8'hc4);
    rx_level = 6'h07;
    wait_irq(1'b0);
    // Trigger of 28 must not fire at 27
    wr_reg(UIC_ADDR_FCTL, 8'hc1);
    rx_level = 6'h1b;
    repeat (4) @(posedge clk);
    #2;
    chk8({7'h00, irq}, 8'h00);
    rx_level = 6'h1c;
    wait_irq(1'b1);
    rx_level = 6'h00;
    wait_irq(1'b0);
    // Transmit ready fires on enable when already empty
    thr_empty = 1'b1;
    wr_reg(UIC_ADDR_MASK, 8'h02);
    wait_irq(1'b1);
    rd_chk(UIC_ADDR_SRC, 8'hc2);
    wait_irq(1'b0);
    rd_chk(UIC_ADDR_SRC, 8'hc1);
    // Overrun outranks transmit ready; transmit stays queued
    pulse(ovr_set);
    wr_reg(UIC_ADDR_MASK, 8'h06);
    wait_irq(1'b1);
    chk8(line_status, 8'h62);
    rd_chk(UIC_ADDR_SRC, 8'hc6);
    rd_chk(UIC_ADDR_LSR, 8'h62);
    rd_chk(UIC_ADDR_SRC, 8'hc2);
    rd_chk(UIC_ADDR_SRC, 8'hc1);
    thr_empty = 1'b0;
    // Modem change, cleared by modem read
    pulse(md_set);
    wr_reg(UIC_ADDR_MASK, 8'h08);
    rd_chk(UIC_ADDR_SRC, 8'hc0);
    rd_chk(UIC_ADDR_MSR, 8'h01);
    rd_chk(UIC_ADDR_SRC, 8'hc1);
    wait_irq(1'b0);
    // Xoff match hidden without enhanced enable
    wr_reg(UIC_ADDR_MASK, 8'h20);
    enh = 1'b0;
    pulse(xoff_set);
    rd_chk(UIC_ADDR_SRC, 8'hc1);
    enh = 1'b1;
    pulse(xoff_set);
    rd_chk(UIC_ADDR_SRC, 8'hd0);
    rd_chk(UIC_ADDR_SRC, 8'hc1);
    wr_reg(UIC_ADDR_FCTL, 8'h00);
    rd_chk(UIC_ADDR_SRC, 8'h01);
    final_report();
  end
endmodule // uic_ctrl_tb
